// file: rtl/dsp_pkg.sv
// Purpose: shared constants for the dual dac serial configuration port
// Assumes: 200 MHz system clock, serial clock sampled as a plain input
// Notes: register contents beyond the port configuration byte are a plain array
package dsp_pkg;
	localparam int SYS_CLK_MHZ = 200;
	localparam int ADDR_W = 5;
	localparam int NUM_REGS = 32;
	localparam logic [4:0] CFG_ADDR = 5'h00;
	localparam logic [4:0] ADDR_TOP = 5'h1F;
	localparam logic [4:0] ADDR_BOTTOM = 5'h00;
	localparam int RW_BIT = 7;
	localparam int CNT_HI_BIT = 6;
	localparam int CNT_LO_BIT = 5;
	localparam int BIT_ORDER_BIT = 6;
	localparam int SOFT_RESET_BIT = 5;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [2:0] BIT_LAST = 3'h7;
	// strap reset pulse: least high time, rounded up to whole cycles
	localparam int STRAP_PULSE_NS = 50;
	localparam int STRAP_PULSE_CYC = (STRAP_PULSE_NS * SYS_CLK_MHZ + 999) / 1000;
	// pin-mode data-format settle wait
	localparam int FORMAT_WAIT_NS = 1000;
	localparam int FORMAT_WAIT_CYC = (FORMAT_WAIT_NS * SYS_CLK_MHZ + 999) / 1000;
	typedef enum logic [1:0] {
		DSP_IDLE = 2'b00,
		DSP_INSTR = 2'b01,
		DSP_DATA = 2'b10
	} dsp_state_type;
endpackage

// file: rtl/dsp_sync.sv
// Purpose: two flip-flop synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to sys_clk
// Notes: the first stage is read only by the second
`timescale 1ns/1ps
module dsp_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk, // system clock
	input wire logic rst_n, // synchronous-released reset, active low
	input wire logic [WIDTH-1:0] async_in, // raw pins
	output logic [WIDTH-1:0] sync_out // synchronised copy
);
	logic [WIDTH-1:0] stage1_reg;

	// two stages, reset to zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1_reg <= '0;
			sync_out <= '0;
		end else begin
			stage1_reg <= async_in;
			sync_out <= stage1_reg;
		end
	end
endmodule

// file: rtl/dsp_port.sv
// Purpose: device side of a three-wire configuration port
// Assumes: serial clock, select, data and strap pins are asynchronous
// Notes: serial clock is oversampled; 200 MHz gives ten samples per 20 MHz bit
`timescale 1ns/1ps
module dsp_port
	import dsp_pkg::*;
(
	input wire logic sys_clk, // system clock, 200 MHz
	input wire logic reset_n, // asynchronous reset, active low
	input wire logic sclk_pin, // serial clock, or clock mode strap
	input wire logic cs_n_pin, // select active low, or power down
	input wire logic sdio_in, // data line level
	output logic sdio_out, // data driven by the device
	output logic sdio_oe, // high while the device drives data
	input wire logic reset_strap_pin, // reset pulse or pin-mode strap
	output logic pin_mode, // pin mode active
	output logic clock_mode_strap, // clock mode in pin mode
	output logic format_strap, // data format in pin mode
	output logic power_down_input, // power down in pin mode
	output logic format_ready, // format strap settled
	output logic bit_order_select, // lsb-first flag
	output logic soft_reset, // soft reset flag of address 0
	output logic [8*dsp_pkg::NUM_REGS-1:0] reg_image // all register bytes
);
	import dsp_pkg::*;

	logic rst_meta_reg, rst_n_reg;
	logic [3:0] pins_sync;
	logic sclk_s, cs_n_s, sdio_s, strap_s;
	logic sclk_d_reg;
	logic rise, fall;
	dsp_state_type state_reg;
	logic [2:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] instr_reg;
	logic [1:0] byte_cnt_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [7:0] regs [NUM_REGS];
	logic [7:0] tx_reg;
	logic [7:0] strap_cnt_reg;
	logic strap_d_reg;
	logic port_clear;
	logic [7:0] rx_byte;
	logic [7:0] fmt_cnt_reg;
	logic fmt_d_reg;
	logic lsb_first;
	logic frame_done_reg;

	// reset release through two flops
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	dsp_sync #(.WIDTH(4)) u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n_reg),
		.async_in({reset_strap_pin, sdio_in, cs_n_pin, sclk_pin}),
		.sync_out(pins_sync)
	);
	assign sclk_s = pins_sync[0];
	assign cs_n_s = pins_sync[1];
	assign sdio_s = pins_sync[2];
	assign strap_s = pins_sync[3];

	// serial clock edge finder on the synchronised copy
	always_ff @(posedge sys_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			sclk_d_reg <= 1'b0;
		end else begin
			sclk_d_reg <= sclk_s;
		end
	end
	assign rise = sclk_s & ~sclk_d_reg & ~cs_n_s & ~pin_mode;
	assign fall = ~sclk_s & sclk_d_reg & ~cs_n_s & ~pin_mode;

	// strap high time counter; a pulse long enough, then low, clears the port
	always_ff @(posedge sys_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			strap_cnt_reg <= 8'h00;
			strap_d_reg <= 1'b0;
		end else begin
			strap_d_reg <= strap_s;
			if (strap_s && strap_cnt_reg < 8'(STRAP_PULSE_CYC)) begin
				strap_cnt_reg <= strap_cnt_reg + 8'h01;
			end else if (!strap_s) begin
				strap_cnt_reg <= 8'h00;
			end
		end
	end
	// a long strap high counts as pin mode; falling edge after a long pulse resets
	assign port_clear = strap_d_reg & ~strap_s & (strap_cnt_reg >= 8'(STRAP_PULSE_CYC));

	// pin mode and strap outputs; straps are only meaningful while strap high
	always_ff @(posedge sys_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			pin_mode <= 1'b0;
			clock_mode_strap <= 1'b0;
			format_strap <= 1'b0;
			power_down_input <= 1'b0;
		end else begin
			pin_mode <= strap_s && strap_cnt_reg >= 8'(STRAP_PULSE_CYC);
			clock_mode_strap <= strap_s & sclk_s;
			format_strap <= strap_s & sdio_s;
			power_down_input <= strap_s & cs_n_s;
		end
	end

	// format settle timer, restarted on any format strap change
	always_ff @(posedge sys_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			fmt_cnt_reg <= 8'h00;
			fmt_d_reg <= 1'b0;
			format_ready <= 1'b0;
		end else begin
			fmt_d_reg <= format_strap;
			if (fmt_d_reg != format_strap) begin
				fmt_cnt_reg <= 8'h00;
			end else if (fmt_cnt_reg < 8'(FORMAT_WAIT_CYC)) begin
				fmt_cnt_reg <= fmt_cnt_reg + 8'h01;
			end
			format_ready <= fmt_cnt_reg >= 8'(FORMAT_WAIT_CYC) && fmt_d_reg == format_strap;
		end
	end

	assign lsb_first = regs[CFG_ADDR][BIT_ORDER_BIT];
	// incoming byte as it will stand after this rising edge
	assign rx_byte = lsb_first ? {sdio_s, shift_reg[7:1]} : {shift_reg[6:0], sdio_s};

	// port sequencer: instruction then data bytes
	always_ff @(posedge sys_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			state_reg <= DSP_IDLE;
			bit_cnt_reg <= 3'h0;
			shift_reg <= 8'h00;
			instr_reg <= 8'h00;
			byte_cnt_reg <= 2'h0;
			addr_reg <= '0;
			frame_done_reg <= 1'b0;
		end else if (port_clear || cs_n_s || pin_mode) begin
			state_reg <= DSP_IDLE;
			bit_cnt_reg <= 3'h0;
			shift_reg <= 8'h00;
			frame_done_reg <= 1'b0;
		end else begin
			if (state_reg == DSP_IDLE && !frame_done_reg) begin
				state_reg <= DSP_INSTR;
			end
			if (rise && !frame_done_reg) begin
				shift_reg <= rx_byte;
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
				if (bit_cnt_reg == BIT_LAST) begin
					if (state_reg != DSP_DATA) begin
						instr_reg <= rx_byte;
						addr_reg <= rx_byte[ADDR_W-1:0];
						byte_cnt_reg <= {rx_byte[CNT_HI_BIT], rx_byte[CNT_LO_BIT]};
						state_reg <= DSP_DATA;
					end else if (byte_cnt_reg == 2'h0) begin
						// without this flag the idle state would take stray rises as a new instruction
						state_reg <= DSP_IDLE; // further edges ignored until select rises
						bit_cnt_reg <= 3'h0;
						frame_done_reg <= 1'b1;
					end else begin
						byte_cnt_reg <= byte_cnt_reg - 2'h1;
						// order taken after a possible config write in this byte
						if ((addr_reg == CFG_ADDR && !instr_reg[RW_BIT]) ? rx_byte[BIT_ORDER_BIT] : lsb_first) begin
							addr_reg <= addr_reg + 5'h01;
						end else begin
							addr_reg <= addr_reg - 5'h01;
						end
					end
				end
			end
		end
	end

	// register array; writes land at the last bit of each byte
	always_ff @(posedge sys_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs[i] <= (i == 0) ? CFG_RESET : REG_RESET;
			end
		end else if (port_clear) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs[i] <= (i == 0) ? CFG_RESET : REG_RESET;
			end
		end else if (regs[CFG_ADDR][SOFT_RESET_BIT] || pin_mode) begin
			for (int i = 1; i < NUM_REGS; i++) begin
				regs[i] <= REG_RESET;
			end
			if (rise && state_reg == DSP_DATA && bit_cnt_reg == BIT_LAST && !instr_reg[RW_BIT]
				&& addr_reg == CFG_ADDR) begin
				regs[CFG_ADDR] <= rx_byte; // release of soft reset
			end
		end else if (rise && state_reg == DSP_DATA && bit_cnt_reg == BIT_LAST && !instr_reg[RW_BIT]) begin
			regs[addr_reg] <= rx_byte;
		end
	end

	// read launch: load on the falling edge that opens each data bit
	always_ff @(posedge sys_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			tx_reg <= 8'h00;
			sdio_out <= 1'b0;
			sdio_oe <= 1'b0;
		end else if (cs_n_s || pin_mode || port_clear) begin
			sdio_oe <= 1'b0;
			sdio_out <= 1'b0;
		end else if (fall && state_reg == DSP_DATA && instr_reg[RW_BIT]) begin
			sdio_oe <= 1'b1;
			if (bit_cnt_reg == 3'h0) begin
				tx_reg <= lsb_first ? {1'b0, regs[addr_reg][7:1]} : {regs[addr_reg][6:0], 1'b0};
				sdio_out <= lsb_first ? regs[addr_reg][0] : regs[addr_reg][7];
			end else begin
				tx_reg <= lsb_first ? {1'b0, tx_reg[7:1]} : {tx_reg[6:0], 1'b0};
				sdio_out <= lsb_first ? tx_reg[0] : tx_reg[7];
			end
		end else if (state_reg != DSP_DATA) begin
			sdio_oe <= 1'b0;
		end
	end

	// status outputs straight from flops
	always_ff @(posedge sys_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			bit_order_select <= 1'b0;
			soft_reset <= 1'b0;
			reg_image <= '0;
		end else begin
			bit_order_select <= regs[CFG_ADDR][BIT_ORDER_BIT];
			soft_reset <= regs[CFG_ADDR][SOFT_RESET_BIT];
			for (int i = 0; i < NUM_REGS; i++) begin
				reg_image[8*i +: 8] <= regs[i];
			end
		end
	end

	property p_hiz;
		@(posedge sys_clk) disable iff (!rst_n_reg) cs_n_s |=> !sdio_oe;
	endproperty
	a_hiz: assert property (p_hiz) else $error("data line driven while deselected");
	property p_no_drive_write;
		@(posedge sys_clk) disable iff (!rst_n_reg) sdio_oe |-> instr_reg[RW_BIT];
	endproperty
	a_no_drive_write: assert property (p_no_drive_write) else $error("driven during write");
	property p_instr_to_data;
		@(posedge sys_clk) disable iff (!rst_n_reg)
			rise && state_reg == DSP_INSTR && bit_cnt_reg == BIT_LAST && !cs_n_s && !port_clear && !pin_mode
			|=> state_reg == DSP_DATA && addr_reg == instr_reg[ADDR_W-1:0];
	endproperty
	a_instr_to_data: assert property (p_instr_to_data) else $error("instruction not taken");
	property p_drive_on_fall;
		@(posedge sys_clk) disable iff (!rst_n_reg) $rose(sdio_oe) |-> $past(fall);
	endproperty
	a_drive_on_fall: assert property (p_drive_on_fall) else $error("drive not on falling edge");
	property p_deselect_clears;
		@(posedge sys_clk) disable iff (!rst_n_reg) cs_n_s |=> bit_cnt_reg == 3'h0 && state_reg == DSP_IDLE;
	endproperty
	a_deselect_clears: assert property (p_deselect_clears) else $error("counters not cleared");
	property p_soft_reset;
		@(posedge sys_clk) disable iff (!rst_n_reg) soft_reset && !port_clear ##1 !port_clear |-> reg_image[15:8] == REG_RESET;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset left a register set");
	property p_order_flag;
		@(posedge sys_clk) disable iff (!rst_n_reg) bit_order_select == $past(regs[CFG_ADDR][BIT_ORDER_BIT]);
	endproperty
	a_order_flag: assert property (p_order_flag) else $error("bit order flag mismatch");
	property p_strap_clear;
		@(posedge sys_clk) disable iff (!rst_n_reg) port_clear |=> state_reg == DSP_IDLE && regs[1] == REG_RESET;
	endproperty
	a_strap_clear: assert property (p_strap_clear) else $error("strap pulse did not reset");
	property p_done_ignores;
		@(posedge sys_clk) disable iff (!rst_n_reg) frame_done_reg && rise |=> state_reg == DSP_IDLE && bit_cnt_reg == 3'h0;
	endproperty
	a_done_ignores: assert property (p_done_ignores) else $error("edge taken after the last byte");
	c_read: cover property (@(posedge sys_clk) disable iff (!rst_n_reg) $rose(sdio_oe));
	c_write: cover property (@(posedge sys_clk) disable iff (!rst_n_reg)
		rise && state_reg == DSP_DATA && bit_cnt_reg == BIT_LAST && !instr_reg[RW_BIT]);
	c_lsb: cover property (@(posedge sys_clk) disable iff (!rst_n_reg) $rose(bit_order_select));
	c_pin: cover property (@(posedge sys_clk) disable iff (!rst_n_reg) $rose(pin_mode));
endmodule

// file: tb/dsp_host.sv
// Purpose: serial host model for the three-wire configuration port
// Assumes: serial clock idles low between frames, 160 ns period
// Notes: the bench resolves the shared data line from both enables
`timescale 1ns/1ps
module dsp_host (
	output logic sclk, // serial clock
	output logic cs_n, // select, active low
	output logic hd, // host data bit
	output logic hoe, // high while the host drives data
	input wire logic line // resolved data line
);
	// idle: deselected, clock still, line released
	initial begin
		sclk = 0;
		cs_n = 1;
		hd = 0;
		hoe = 0;
	end
	// select edge; high time covers the device's minimum gap
	task automatic sel(input logic v);
		cs_n = v;
		hoe = !v;
		#40;
	endtask
	// data set at the fall, rise mid-bit; reads sampled at the rise
	task automatic shift(input logic [7:0] b, input logic lo, input int nb, output logic [7:0] r);
		for (int i = 0; i < nb; i++) begin
			hd = lo ? b[i] : b[7-i];
			#80 sclk = 1;
			if (lo) r[i] = line;
			else r[7-i] = line;
			#80 sclk = 0;
		end
	endtask
	// whole cycle: instruction then 1..4 bytes, order per byte in om
	task automatic xfer(input logic rd, input logic [1:0] n, input logic [4:0] a, input logic [31:0] wd,
		input logic [4:0] om, output logic [31:0] q);
		logic [7:0] r;
		q = '0;
		sel(1'b0);
		shift({rd, n, a}, om[0], 8, r);
		hoe = !rd;
		for (int k = 0; k <= n; k++) begin
			shift(wd[8*k+:8], om[k+1], 8, r);
			q[8*k+:8] = r;
		end
		sel(1'b1);
	endtask
	// pin-mode strap levels on the serial pins
	task automatic pins(input logic c, input logic d, input logic s);
		sclk = c;
		hd = d;
		cs_n = s;
		hoe = 1;
	endtask
endmodule

// file: tb/dsp_port_tb.sv
// Purpose: self-checking bench for the configuration port
// Assumes: host model at 160 ns serial period, 200 MHz system clock
// Notes: expected registers live in a shadow image em
`timescale 1ns/1ps
`define CHK(a, e, m) begin num_checks++; if ((a) !== (e)) begin fails++; $display("BAD t=%0t %s", $time, m); end end
module dsp_port_tb;
	import dsp_pkg::*;
	logic sys_clk = 0;
	logic reset_n = 0;
	logic strap = 0;
	logic junk = 0;
	logic sclk, cs_n, hd, hoe, line, sdio_out, sdio_oe;
	logic pin_mode, cms, fms, pdi, frdy, bos, srst;
	logic [8*NUM_REGS-1:0] img, em;
	logic [7:0] r8;
	int fails = 0;
	int num_checks = 0;
	// clock, and a toggling level so a released line never looks driven
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) junk <= ~junk;
	assign line = sdio_oe ? sdio_out : (hoe ? hd : junk);
	dsp_host dsp_host_inst (.sclk(sclk), .cs_n(cs_n), .hd(hd), .hoe(hoe), .line(line));
	dsp_port dsp_port_inst (.sys_clk(sys_clk), .reset_n(reset_n), .sclk_pin(sclk), .cs_n_pin(cs_n), .sdio_in(line),
		.sdio_out(sdio_out), .sdio_oe(sdio_oe), .reset_strap_pin(strap), .pin_mode(pin_mode),
		.clock_mode_strap(cms), .format_strap(fms), .power_down_input(pdi), .format_ready(frdy),
		.bit_order_select(bos), .soft_reset(srst), .reg_image(img));
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// write; order and address step follow reg 0 as each byte lands
	task automatic wr(input logic [4:0] a, input logic [1:0] n, input logic [31:0] wd);
		logic [31:0] q;
		logic [4:0] om;
		logic [4:0] p;
		p = a;
		om[0] = em[6];
		for (int k = 0; k <= n; k++) begin
			om[k+1] = em[6];
			if (p == 0 || !em[5]) em[8*p+:8] = wd[8*k+:8];
			p = em[6] ? p + 5'h01 : p - 5'h01;
		end
		if (em[5]) em[255:8] = '0;
		dsp_host_inst.xfer(1'b0, n, a, wd, {5{om[0]}} & 5'h00 | om, q);
	endtask
	// read and compare against the shadow image
	task automatic rd(input logic [4:0] a, input logic [1:0] n);
		logic [31:0] q;
		logic [31:0] e;
		logic [4:0] p;
		p = a;
		e = '0;
		for (int k = 0; k <= n; k++) begin
			e[8*k+:8] = em[8*p+:8];
			p = em[6] ? p + 5'h01 : p - 5'h01;
		end
		dsp_host_inst.xfer(1'b1, n, a, 32'h0000_0000, {5{em[6]}}, q);
		`CHK(q, e, "read data")
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	task automatic complete_run;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		em = '0;
		cyc(5);
		reset_n = 1;
		cyc(10);
		`CHK({pin_mode, bos, srst, sdio_oe, img}, '0, "reset state")
		for (int n = 0; n < 4; n++) wr(5'(4 * n + 3), 2'(n), 32'hA1B2_C3D4 + n);
		`CHK(img, em, "msb writes")
		for (int n = 0; n < 4; n++) rd(5'(4 * n + 3), 2'(n));
		`CHK(sdio_oe, 1'b0, "line released")
		done("msb");
		wr(5'h00, 2'h0, 32'h0000_0040);
		`CHK(bos, 1'b1, "lsb flag")
		wr(5'h1E, 2'h1, 32'h0000_5A3C);
		`CHK(img, em, "lsb writes")
		rd(5'h1D, 2'h2);
		done("lsb");
		// order flips after byte 0, so byte 1 goes msb first to 0x1F
		wr(5'h00, 2'h1, 32'h0000_7700);
		`CHK({bos, img}, {1'b0, em}, "config mid cycle")
		done("midcfg");
		wr(5'h00, 2'h0, 32'h0000_0020);
		wr(5'h08, 2'h0, 32'h0000_0099);
		`CHK({srst, img}, {1'b1, em}, "soft reset")
		wr(5'h00, 2'h0, 32'h0000_0000);
		done("swreset");
		// partial byte dropped when select rises
		dsp_host_inst.sel(1'b0);
		dsp_host_inst.shift(8'h03, 1'b0, 8, r8);
		dsp_host_inst.shift(8'hFF, 1'b0, 5, r8);
		dsp_host_inst.sel(1'b1);
		wr(5'h04, 2'h0, 32'h0000_003C);
		`CHK(img, em, "abort")
		// rises after the counted bytes must not open a second instruction
		dsp_host_inst.sel(1'b0);
		dsp_host_inst.shift(8'h04, 1'b0, 8, r8);
		dsp_host_inst.shift(8'h5A, 1'b0, 8, r8);
		dsp_host_inst.shift(8'h05, 1'b0, 8, r8);
		dsp_host_inst.shift(8'hEE, 1'b0, 8, r8);
		dsp_host_inst.sel(1'b1);
		em[39:32] = 8'h5A;
		`CHK(img, em, "extra rises")
		done("abort");
		// strap pulse mid-byte, then a fresh instruction in the same frame
		dsp_host_inst.sel(1'b0);
		dsp_host_inst.shift(8'h05, 1'b0, 8, r8);
		dsp_host_inst.shift(8'hFF, 1'b0, 4, r8);
		strap = 1;
		cyc(12);
		strap = 0;
		cyc(6);
		dsp_host_inst.shift(8'h06, 1'b0, 8, r8);
		dsp_host_inst.shift(8'h81, 1'b0, 8, r8);
		dsp_host_inst.sel(1'b1);
		em = '0;
		em[55:48] = 8'h81;
		`CHK(img, em, "strap reset")
		done("strap");
		strap = 1;
		dsp_host_inst.pins(1'b1, 1'b1, 1'b1);
		cyc(20);
		`CHK({pin_mode, cms, fms, pdi}, 4'hF, "straps high")
		dsp_host_inst.pins(1'b0, 1'b0, 1'b0);
		cyc(50);
		`CHK({pin_mode, cms, fms, pdi, frdy}, 5'h10, "straps low")
		cyc(200);
		`CHK(frdy, 1'b1, "format settled")
		strap = 0;
		dsp_host_inst.sel(1'b1);
		cyc(20);
		em = '0;
		`CHK({pin_mode, img}, {1'b0, em}, "leave pin mode")
		done("pinmode");
		complete_run();
	end
	// hang guard
	initial begin
		#400000;
		fails++;
		$display("BAD t=%0t timeout", $time);
		complete_run();
	end
endmodule
